// ===== accel_pkg.sv
// Operation
// - identity registers read fixed codes
// - revision register reads silicon revision
// - serial register reads trim serial value
// - key write restarts init, clears config
// - signed offset trim added per axis
// - activity compares against unsigned threshold
// - inactivity compares against unsigned threshold
// - inactivity needs below-threshold for programmed seconds
// - inactivity uses filtered data, one sample
// - zero time fires once below threshold
// - coupling bit: 0 dc, 1 ac
// - ac activity references start sample
// - ac inactivity refreshes reference when exceeded
// - axis bits include axes; none disables
// - activity ORs participating axes
// - inactivity ANDs participating axes
// - reduced-power bit selects low power
// - rate field resets to 100 Hz
// - run bit: standby or measure; standby
// - chaining alternates inactivity then activity
// - dormant suppresses ready, inactivity
// - dormant rate codes give 8,4,2,1 Hz
package accel_pkg;
    // ********************************
    // register map
    // ********************************
    localparam logic [7:0] ADDR_MANUF   = 8'h00;
    localparam logic [7:0] ADDR_TRACE   = 8'h01;
    localparam logic [7:0] ADDR_PART    = 8'h02;
    localparam logic [7:0] ADDR_REV     = 8'h03;
    localparam logic [7:0] ADDR_SERIAL  = 8'h04;
    localparam logic [7:0] ADDR_RESET   = 8'h18;
    localparam logic [7:0] ADDR_OFS_X   = 8'h1e;
    localparam logic [7:0] ADDR_OFS_Y   = 8'h1f;
    localparam logic [7:0] ADDR_OFS_Z   = 8'h20;
    localparam logic [7:0] ADDR_ACT_THR = 8'h24;
    localparam logic [7:0] ADDR_INA_THR = 8'h25;
    localparam logic [7:0] ADDR_INA_TIM = 8'h26;
    localparam logic [7:0] ADDR_AXIS    = 8'h27;
    localparam logic [7:0] ADDR_RATE    = 8'h2c;
    localparam logic [7:0] ADDR_POWER   = 8'h2d;
    // reset values and write masks
    localparam logic [7:0] ZERO_RESET   = 8'h00;
    localparam logic [7:0] RATE_RESET   = 8'h0a;
    localparam logic [7:0] RESET_KEY    = 8'h52;
    localparam logic [7:0] RATE_WMASK   = 8'h1f;
    localparam logic [7:0] POWER_WMASK  = 8'h7f;
    // field positions
    localparam int ACT_AC_BIT   = 7;
    localparam int ACT_AX_LSB   = 4;
    localparam int INA_AC_BIT   = 3;
    localparam int INA_AX_LSB   = 0;
    localparam int LOWPWR_BIT   = 4;
    localparam int I2C_OFF_BIT  = 6;
    localparam int LINK_BIT     = 5;
    localparam int AUTOSLP_BIT  = 4;
    localparam int MEASURE_BIT  = 3;
    localparam int SLEEP_BIT    = 2;
    // scale shifts: trim 4 lsb, threshold 16 lsb
    localparam int OFS_SHIFT    = 2;
    localparam int THR_SHIFT    = 4;
    // one second of clock cycles
    localparam int CLK_NS       = 10;
    localparam int SECOND_NS    = 1000000000;
    localparam int SEC_CYCLES   = SECOND_NS / CLK_NS;
    localparam logic [3:0] DORMANT_MAX_HZ = 4'h8;

    // three signed axis samples
    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } sample_type;

    // register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_type;

    // decoded operating mode
    typedef struct packed {
        logic [3:0] rate;
        logic       lowPower;
        logic       i2cOff;
        logic       link;
        logic       autoSleep;
        logic       measure;
        logic       sleep;
        logic [1:0] wake;
        logic [3:0] dormantHz;
    } mode_type;

    // chaining state
    typedef enum logic [1:0] {
        CHAIN_WAIT_INACT = 2'b01,
        CHAIN_WAIT_ACT   = 2'b10
    } chain_type;
endpackage

// ===== motion_axis_cmp.sv
`timescale 1ns/1ps
// one axis: magnitude against scaled threshold
module motion_axis_cmp #(
    parameter int W = 16
) (
    // sample and reference
    input  wire logic signed [W-1:0] value,
    input  wire logic signed [W-1:0] refValue,
    input  wire logic                acMode,
    // threshold in register counts
    input  wire logic [7:0]          thr,
    // compare results
    output logic                     over,
    output logic                     under
);
    import accel_pkg::*;
    logic signed [W:0] diff;     // signed difference
    logic        [W:0] mag;      // magnitude
    logic        [W:0] thrS;     // threshold in lsb

    // ac subtracts the reference, dc uses value itself
    always_comb begin
        diff = acMode ? (W+1)'(value) - (W+1)'(refValue)
                      : (W+1)'(value);
        mag  = diff[W] ? (W+1)'(-diff) : (W+1)'(diff);
        thrS = (W+1)'({thr, 4'h0}) >> (4 - THR_SHIFT);
        over  = mag > thrS;
        under = mag < thrS;
    end
endmodule

// ===== accel_config_motion_detect.sv
`timescale 1ns/1ps
module accel_config_motion_detect
    import accel_pkg::*;
#(
    parameter logic [7:0] MANUF_CODE  = 8'h5a, // arbitrary value
    parameter logic [7:0] TRACE_CODE  = 8'h3c, // arbitrary value
    parameter logic [7:0] PART_CODE   = 8'h71, // arbitrary value
    parameter logic [7:0] REV_CODE    = 8'h00, // arbitrary value
    parameter logic [7:0] SERIAL_CODE = 8'h00, // arbitrary value
    parameter int         SEC_TICKS   = SEC_CYCLES
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // register port from serial logic
    input  wire accel_pkg::reg_req_type  regReq,
    output logic [7:0]                   rdData,
    // sensing core samples
    input  wire logic                    rawValid,
    input  wire accel_pkg::sample_type   rawSample,
    input  wire logic                    filtValid,
    input  wire accel_pkg::sample_type   filtSample,
    // trimmed output data
    output logic                         dataReady,
    output accel_pkg::sample_type        dataOut,
    // mode and restart
    output accel_pkg::mode_type          mode,
    output logic                         initRestart,
    // motion events
    output logic                         activityEvent,
    output logic                         inactivityEvent
);
    import accel_pkg::*;

    // ********************************
    // register file
    // ********************************
    logic [7:0] ofs_ff [3];          // per-axis trims
    logic [7:0] nxt_ofs [3];
    logic [7:0] actThr_ff, nxt_actThr;    // motion_threshold
    logic [7:0] inaThr_ff, nxt_inaThr;    // stillness_threshold
    logic [7:0] inaTime_ff, nxt_inaTime;  // stillness_duration
    logic [7:0] axis_ff, nxt_axis;        // motion_axis_control
    logic [7:0] rate_ff, nxt_rate;        // rate_and_power_select
    logic [7:0] power_ff, nxt_power;      // power_mode_control
    logic [7:0] resetCmd_ff, nxt_resetCmd;
    logic [7:0] rdData_ff, nxt_rdData;
    logic       restart_ff, nxt_restart;
    logic       keyHit;              // soft reset key written

    assign keyHit = regReq.wr && regReq.addr == ADDR_RESET
                    && regReq.data == RESET_KEY;

    // next register values and read mux
    always_comb begin
        nxt_ofs      = ofs_ff;
        nxt_actThr   = actThr_ff;
        nxt_inaThr   = inaThr_ff;
        nxt_inaTime  = inaTime_ff;
        nxt_axis     = axis_ff;
        nxt_rate     = rate_ff;
        nxt_power    = power_ff;
        nxt_resetCmd = resetCmd_ff;
        nxt_rdData   = rdData_ff;
        nxt_restart  = 1'b0;
        if (regReq.rd) begin
            unique case (regReq.addr)
                ADDR_MANUF:   nxt_rdData = MANUF_CODE;
                ADDR_TRACE:   nxt_rdData = TRACE_CODE;
                ADDR_PART:    nxt_rdData = PART_CODE;
                ADDR_REV:     nxt_rdData = REV_CODE;
                ADDR_SERIAL:  nxt_rdData = SERIAL_CODE;
                ADDR_RESET:   nxt_rdData = resetCmd_ff;
                ADDR_OFS_X:   nxt_rdData = ofs_ff[0];
                ADDR_OFS_Y:   nxt_rdData = ofs_ff[1];
                ADDR_OFS_Z:   nxt_rdData = ofs_ff[2];
                ADDR_ACT_THR: nxt_rdData = actThr_ff;
                ADDR_INA_THR: nxt_rdData = inaThr_ff;
                ADDR_INA_TIM: nxt_rdData = inaTime_ff;
                ADDR_AXIS:    nxt_rdData = axis_ff;
                ADDR_RATE:    nxt_rdData = rate_ff & RATE_WMASK;
                ADDR_POWER:   nxt_rdData = power_ff & POWER_WMASK;
                default:      nxt_rdData = ZERO_RESET; // reserved
            endcase
        end
        if (keyHit) begin
            // back to power-on configuration
            nxt_ofs      = '{ZERO_RESET, ZERO_RESET, ZERO_RESET};
            nxt_actThr   = ZERO_RESET;
            nxt_inaThr   = ZERO_RESET;
            nxt_inaTime  = ZERO_RESET;
            nxt_axis     = ZERO_RESET;
            nxt_rate     = RATE_RESET;
            nxt_power    = ZERO_RESET;
            nxt_resetCmd = ZERO_RESET;
            nxt_restart  = 1'b1;
        end else if (regReq.wr) begin
            unique case (regReq.addr)
                ADDR_RESET:   nxt_resetCmd = regReq.data;
                ADDR_OFS_X:   nxt_ofs[0] = regReq.data;
                ADDR_OFS_Y:   nxt_ofs[1] = regReq.data;
                ADDR_OFS_Z:   nxt_ofs[2] = regReq.data;
                ADDR_ACT_THR: nxt_actThr = regReq.data;
                ADDR_INA_THR: nxt_inaThr = regReq.data;
                ADDR_INA_TIM: nxt_inaTime = regReq.data;
                ADDR_AXIS:    nxt_axis = regReq.data;
                ADDR_RATE:    nxt_rate = regReq.data & RATE_WMASK;
                ADDR_POWER:   nxt_power = regReq.data & POWER_WMASK;
                default:      nxt_rdData = nxt_rdData; // read-only
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ofs_ff      <= '{ZERO_RESET, ZERO_RESET, ZERO_RESET};
            actThr_ff   <= ZERO_RESET;
            inaThr_ff   <= ZERO_RESET;
            inaTime_ff  <= ZERO_RESET;
            axis_ff     <= ZERO_RESET;
            rate_ff     <= RATE_RESET;
            power_ff    <= ZERO_RESET;
            resetCmd_ff <= ZERO_RESET;
            rdData_ff   <= ZERO_RESET;
            restart_ff  <= 1'b0;
        end else begin
            ofs_ff      <= nxt_ofs;
            actThr_ff   <= nxt_actThr;
            inaThr_ff   <= nxt_inaThr;
            inaTime_ff  <= nxt_inaTime;
            axis_ff     <= nxt_axis;
            rate_ff     <= nxt_rate;
            power_ff    <= nxt_power;
            resetCmd_ff <= nxt_resetCmd;
            rdData_ff   <= nxt_rdData;
            restart_ff  <= nxt_restart;
        end
    end

    // decoded mode fields
    always_comb begin
        mode.rate      = rate_ff[3:0];
        mode.lowPower  = rate_ff[LOWPWR_BIT];
        mode.i2cOff    = power_ff[I2C_OFF_BIT];
        mode.link      = power_ff[LINK_BIT];
        mode.autoSleep = power_ff[AUTOSLP_BIT];
        mode.measure   = power_ff[MEASURE_BIT];
        mode.sleep     = power_ff[SLEEP_BIT];
        mode.wake      = power_ff[1:0];
        mode.dormantHz = DORMANT_MAX_HZ >> power_ff[1:0];
    end

    assign rdData      = rdData_ff;
    assign initRestart = restart_ff;

    // ********************************
    // offset trim and output data
    // ********************************
    function automatic logic signed [15:0] trim(
        input logic signed [15:0] v,
        input logic        [7:0]  o);
        return v + (16'(signed'(o)) <<< OFS_SHIFT);
    endfunction

    sample_type dataOut_ff, nxt_dataOut;
    logic       ready_ff, nxt_ready;

    // trimmed sample; ready withheld in dormant mode
    always_comb begin
        nxt_dataOut = dataOut_ff;
        nxt_ready   = 1'b0;
        if (rawValid && mode.measure) begin
            nxt_dataOut.x = trim(rawSample.x, ofs_ff[0]);
            nxt_dataOut.y = trim(rawSample.y, ofs_ff[1]);
            nxt_dataOut.z = trim(rawSample.z, ofs_ff[2]);
            nxt_ready     = !mode.sleep;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataOut_ff <= '0;
            ready_ff   <= 1'b0;
        end else begin
            dataOut_ff <= nxt_dataOut;
            ready_ff   <= nxt_ready;
        end
    end

    assign dataOut   = dataOut_ff;
    assign dataReady = ready_ff;

    // ********************************
    // motion detection
    // ********************************
    logic [2:0] actAx, inaAx;        // participation masks
    logic       actAc, inaAc;        // coupling selects
    logic       chainOn, actOn, inaOn;
    logic [2:0] actOver, actUnder, inaOver, inaUnder;
    logic signed [15:0] rawV [3], filtV [3], actRefV [3], inaRefV [3];

    sample_type actRef_ff, nxt_actRef;
    sample_type inaRef_ff, nxt_inaRef;
    logic       actRefOk_ff, nxt_actRefOk;
    logic       inaRefOk_ff, nxt_inaRefOk;
    chain_type  chain_ff, nxt_chain;
    logic [31:0] secDiv_ff, nxt_secDiv;  // cycles within second
    logic [7:0] secCnt_ff, nxt_secCnt;   // seconds below threshold
    logic       below_ff, nxt_below;     // last filtered sample still
    logic       seen_ff, nxt_seen;       // filtered sample arrived
    logic       fired_ff, nxt_fired;     // inactivity already sent
    logic       actEv_ff, nxt_actEv;
    logic       inaEv_ff, nxt_inaEv;

    assign actAx = axis_ff[ACT_AX_LSB +: 3];
    assign inaAx = axis_ff[INA_AX_LSB +: 3];
    assign actAc = axis_ff[ACT_AC_BIT];
    assign inaAc = axis_ff[INA_AC_BIT];
    assign chainOn = mode.link && |actAx && |inaAx;
    // functions need a participating axis and measurement
    assign actOn = mode.measure && |actAx
                   && !(chainOn && chain_ff == CHAIN_WAIT_INACT);
    assign inaOn = mode.measure && |inaAx && !mode.sleep
                   && !(chainOn && chain_ff == CHAIN_WAIT_ACT);
    assign rawV    = '{rawSample.x, rawSample.y, rawSample.z};
    assign filtV   = '{filtSample.x, filtSample.y, filtSample.z};
    assign actRefV = '{actRef_ff.x, actRef_ff.y, actRef_ff.z};
    assign inaRefV = '{inaRef_ff.x, inaRef_ff.y, inaRef_ff.z};

    // per-axis compares, index 0 is x to match mask bit 2
    for (genvar i = 0; i < 3; i++) begin : g_axis
        motion_axis_cmp #(.W(16)) u_act (
            .value    (rawV[i]),
            .refValue (actRefV[i]),
            .acMode   (actAc),
            .thr      (actThr_ff),
            .over     (actOver[2-i]),
            .under    (actUnder[2-i])
        );
        motion_axis_cmp #(.W(16)) u_ina (
            .value    (filtV[i]),
            .refValue (inaRefV[i]),
            .acMode   (inaAc),
            .thr      (inaThr_ff),
            .over     (inaOver[2-i]),
            .under    (inaUnder[2-i])
        );
    end

    // detection next state
    always_comb begin
        nxt_actRef   = actRef_ff;
        nxt_inaRef   = inaRef_ff;
        nxt_actRefOk = actRefOk_ff;
        nxt_inaRefOk = inaRefOk_ff;
        nxt_chain    = chain_ff;
        nxt_secDiv   = secDiv_ff;
        nxt_secCnt   = secCnt_ff;
        nxt_below    = below_ff;
        nxt_seen     = seen_ff;
        nxt_fired    = fired_ff;
        nxt_actEv    = 1'b0;
        nxt_inaEv    = 1'b0;
        // activity: reference taken at detection start
        if (!actOn) begin
            nxt_actRefOk = 1'b0;
        end else if (rawValid && actAc && !actRefOk_ff) begin
            nxt_actRef   = rawSample;
            nxt_actRefOk = 1'b1;
        end else if (rawValid && |(actOver & actAx)) begin
            nxt_actEv = 1'b1;
            if (chainOn) begin
                nxt_chain = CHAIN_WAIT_INACT;
            end
        end
        // inactivity: filtered samples, all participating axes still
        if (!inaOn) begin
            nxt_seen     = 1'b0;
            nxt_below    = 1'b0;
            nxt_fired    = 1'b0;
            nxt_inaRefOk = 1'b0;
            nxt_secDiv   = '0;
            nxt_secCnt   = '0;
        end else begin
            if (filtValid) begin
                nxt_seen = 1'b1;
                if (inaAc && (!inaRefOk_ff || |(inaOver & inaAx))) begin
                    nxt_inaRef   = filtSample;
                    nxt_inaRefOk = 1'b1;
                    nxt_below    = 1'b0;
                end else begin
                    nxt_below = &(inaUnder | ~inaAx);
                end
            end
            if (!nxt_below) begin
                nxt_secDiv = '0;
                nxt_secCnt = '0;
                nxt_fired  = 1'b0;
            end else if (secDiv_ff == 32'(SEC_TICKS - 1)) begin
                nxt_secDiv = '0;
                if (secCnt_ff != 8'hff) begin
                    nxt_secCnt = secCnt_ff + 8'h01;
                end
            end else begin
                nxt_secDiv = secDiv_ff + 32'h1;
            end
            if (seen_ff && below_ff && nxt_below && !fired_ff
                && secCnt_ff >= inaTime_ff) begin
                nxt_inaEv = 1'b1;
                nxt_fired = 1'b1;
                if (chainOn) begin
                    nxt_chain = CHAIN_WAIT_ACT;
                end
            end
        end
        if (!chainOn) begin
            nxt_chain = CHAIN_WAIT_INACT;
        end
        if (keyHit) begin
            nxt_chain = CHAIN_WAIT_INACT;
        end
    end

    // detection registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            actRef_ff   <= '0;
            inaRef_ff   <= '0;
            actRefOk_ff <= 1'b0;
            inaRefOk_ff <= 1'b0;
            chain_ff    <= CHAIN_WAIT_INACT;
            secDiv_ff   <= '0;
            secCnt_ff   <= '0;
            below_ff    <= 1'b0;
            seen_ff     <= 1'b0;
            fired_ff    <= 1'b0;
            actEv_ff    <= 1'b0;
            inaEv_ff    <= 1'b0;
        end else begin
            actRef_ff   <= nxt_actRef;
            inaRef_ff   <= nxt_inaRef;
            actRefOk_ff <= nxt_actRefOk;
            inaRefOk_ff <= nxt_inaRefOk;
            chain_ff    <= nxt_chain;
            secDiv_ff   <= nxt_secDiv;
            secCnt_ff   <= nxt_secCnt;
            below_ff    <= nxt_below;
            seen_ff     <= nxt_seen;
            fired_ff    <= nxt_fired;
            actEv_ff    <= nxt_actEv;
            inaEv_ff    <= nxt_inaEv;
        end
    end

    assign activityEvent   = actEv_ff;
    assign inactivityEvent = inaEv_ff;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence keyWrite;
        regReq.wr && regReq.addr == ADDR_RESET
        && regReq.data == RESET_KEY;
    endsequence

    ident_read_a: assert property (
        regReq.rd && regReq.addr == ADDR_PART |=> rdData == PART_CODE)
        else $error("part code read wrong");
    rev_read_a: assert property (
        regReq.rd && regReq.addr == ADDR_REV |=> rdData == REV_CODE)
        else $error("revision read wrong");
    serial_read_a: assert property (
        regReq.rd && regReq.addr == ADDR_SERIAL |=> rdData == SERIAL_CODE)
        else $error("serial read wrong");
    soft_reset_a: assert property (
        keyWrite |=> initRestart && rate_ff == RATE_RESET
        && actThr_ff == ZERO_RESET && power_ff == ZERO_RESET)
        else $error("soft reset did not clear config");
    trim_add_a: assert property (
        rawValid && mode.measure |=> dataOut.x == trim(
        $past(rawSample.x), $past(ofs_ff[0])))
        else $error("trim not applied");
    rate_zero_a: assert property (
        regReq.rd && regReq.addr == ADDR_RATE |=> rdData[7:5] == 3'h0)
        else $error("fixed-zero rate bits read high");
    no_axis_a: assert property (
        actAx == 3'h0 |=> !activityEvent)
        else $error("activity without axes");
    standby_a: assert property (
        !mode.measure ##1 !mode.measure |-> !activityEvent
        && !inactivityEvent && !dataReady)
        else $error("event in standby");
    dormant_a: assert property (
        $past(mode.sleep) |-> !dataReady && !inactivityEvent)
        else $error("ready or inactivity while dormant");
    strobe_a: assert property (
        inactivityEvent |=> !inactivityEvent)
        else $error("inactivity strobe too long");
endmodule

// ===== host_model.sv
`timescale 1ns/1ps
// host side of the register port: byte reads and writes
module host_model (
    // clock
    input  wire logic                   clk,
    // register port
    output accel_pkg::reg_req_type      req,
    input  wire logic [7:0]             rdData
);
    import accel_pkg::*;
    // idle port from time zero
    initial req = '0;
    // one-cycle write strobe, dropped after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk);
        #1;
        req = '0;
    endtask
    // one-cycle read strobe, data taken once registered
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge clk);
        #1;
        req = '0;
        d = rdData;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import accel_pkg::*;
    // ****************
    // bench signals
    // ****************
    localparam logic [7:0] PART = 8'h71; // arbitrary value
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    reg_req_type         req;
    logic [7:0]          rdData;
    logic [7:0]          d;
    logic                rawValid = 1'b0;
    logic                filtValid = 1'b0;
    sample_type          smpIn = '0;
    logic                dataReady;
    sample_type          dataOut;
    mode_type            mode;
    logic                initRestart;
    logic                activityEvent;
    logic                inactivityEvent;
    int                  fails = 0;
    int                  comparisons = 0;
    int                  actN = 0;
    int                  inaN = 0;
    int                  rdyN = 0;
    int                  rstN = 0;
    logic [7:0]          ids [5] = '{8'h5a, 8'h3c, 8'h71, 8'h00, 8'h00};
    always #5 clk = ~clk;
    // pulse counters for the event outputs
    always @(posedge clk) begin
        if (activityEvent === 1'b1) actN++;
        if (inactivityEvent === 1'b1) inaN++;
        if (dataReady === 1'b1) rdyN++;
        if (initRestart === 1'b1) rstN++;
    end
    host_model host (.clk(clk), .req(req), .rdData(rdData));
    accel_config_motion_detect #(.SEC_TICKS(20)) dut (
        .clk(clk), .rst(rst), .regReq(req), .rdData(rdData),
        .rawValid(rawValid), .rawSample(smpIn),
        .filtValid(filtValid), .filtSample(smpIn),
        .dataReady(dataReady), .dataOut(dataOut), .mode(mode),
        .initRestart(initRestart), .activityEvent(activityEvent),
        .inactivityEvent(inactivityEvent));
    // compare and report
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk(d, e);
    endtask
    // one raw (r=1) or filtered (r=0) sample, then settle
    task automatic smp(input logic r, input sample_type s);
        @(posedge clk);
        #1;
        rawValid = r;
        filtValid = !r;
        smpIn = s;
        @(posedge clk);
        #1;
        rawValid = 1'b0;
        filtValid = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        fails++;
        conclude();
    end
    // ****************
    // test sequence
    // ****************
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(mode.rate, 4'ha);
        for (int i = 0; i < 5; i++) rdchk(i[7:0], ids[i]);
        rdchk(ADDR_PART, PART);
        rdchk(8'h05, 8'h00);
        rdchk(ADDR_RATE, 8'h0a);
        host.wr(ADDR_RATE, 8'hff);
        rdchk(ADDR_RATE, 8'h1f);
        chk(mode.lowPower, 1'b1);
        host.wr(ADDR_POWER, 8'hff);
        rdchk(ADDR_POWER, 8'h7f);
        chk(mode, {4'hf, 6'h3f, 2'h3, 4'h1});
        host.wr(ADDR_POWER, 8'h00);
        host.wr(ADDR_OFS_X, 8'hff);
        host.wr(ADDR_ACT_THR, 8'h05);
        host.wr(ADDR_INA_THR, 8'h02);
        host.wr(ADDR_AXIS, 8'h47);
        smp(1'b1, '{16'h0064, 16'h0000, 16'h0000});
        chk(rdyN, 0);
        host.wr(ADDR_POWER, 8'h08);
        // trim of -1 count takes 4 lsb off x
        smp(1'b1, '{16'h0064, 16'h0000, 16'h0000});
        chk(dataOut.x, 16'h0060);
        chk(rdyN, 1);
        chk(actN, 1);
        smp(1'b1, '{16'h0050, 16'h0000, 16'h0000});
        chk(actN, 1);
        smp(1'b1, '{16'h0000, 16'h03e8, 16'hfc18});
        chk(actN, 1);
        smp(1'b0, '{16'h000a, 16'hfff6, 16'h001f});
        chk(inaN, 1);
        smp(1'b0, '{16'h000a, 16'hfff6, 16'h0028});
        chk(inaN, 1);
        // one second of stillness needed before the event
        host.wr(ADDR_INA_TIM, 8'h01);
        smp(1'b0, '{16'h000a, 16'hfff6, 16'h001f});
        chk(inaN, 1);
        repeat (20) @(posedge clk);
        #1;
        chk(inaN, 2);
        host.wr(ADDR_RESET, 8'h52);
        chk(initRestart, 1'b1);
        rdchk(ADDR_ACT_THR, 8'h00);
        chk(rstN, 1);
        rdchk(ADDR_RATE, 8'h0a);
        chk(mode.measure, 1'b0);
        // ac activity: first sample is the reference
        host.wr(ADDR_ACT_THR, 8'h05);
        host.wr(ADDR_AXIS, 8'hc0);
        host.wr(ADDR_POWER, 8'h08);
        smp(1'b1, '{16'h01f4, 16'h0000, 16'h0000});
        smp(1'b1, '{16'h0230, 16'h0000, 16'h0000});
        chk(actN, 1);
        smp(1'b1, '{16'h0258, 16'h0000, 16'h0000});
        chk(actN, 2);
        conclude();
    end
endmodule
